// >>> tb/bss_boot_strap_sampler_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "bss_regs.svh"

module bss_boot_strap_sampler_tb;
  logic                 mclk = 1'b0;
  logic                 rst = 1'b1;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [11:0]          paddr = 12'h000;
  logic [31:0]          pwdata = 32'h00000000;
  logic                 pready, pslverr, strapCaptured, er;
  logic [31:0]          prdata, rd;
  logic [1:0]           bootMethodStrap, bootMethod;
  logic [3:0]           asyncPortConfigStrap, asyncPortConfig;
  logic                 bootLedOut, bootLedOe, serial1SelectZeroOut, serial1SelectZeroOe;
  bss_pkg::bss_pinmux_s padFunctionSelectTwo;
  logic                 drvEn = 1'b1;
  logic [1:0]           drvBoot = 2'h0;
  logic [3:0]           drvAsync = 4'h0;
  logic [3:0]           cfgTab [5] = '{4'h9, 4'h6, 4'h3, 4'hC, 4'hD};
  int                   err_total = 0;
  int                   n_compared = 0;
  int                   cycles = 0;

  always #10 mclk = ~mclk;

  bss_boot_strap_sampler uut (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .bootMethodStrap(bootMethodStrap), .asyncPortConfigStrap(asyncPortConfigStrap),
    .bootMethod(bootMethod), .asyncPortConfig(asyncPortConfig),
    .strapCaptured(strapCaptured), .padFunctionSelectTwo(padFunctionSelectTwo),
    .bootLedOut(bootLedOut), .bootLedOe(bootLedOe),
    .serial1SelectZeroOut(serial1SelectZeroOut), .serial1SelectZeroOe(serial1SelectZeroOe)
  );

  bss_strap_board board (
    .drvEn(drvEn), .drvBoot(drvBoot), .drvAsync(drvAsync), .ledOut(bootLedOut),
    .ledOe(bootLedOe), .bootPins(bootMethodStrap), .asyncPins(asyncPortConfigStrap)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    // only the cycle ceiling ends a wait that never sees pready
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic por(input logic en, input logic [1:0] b, input logic [3:0] a);
    @(posedge mclk);
    rst <= 1'b1;
    drvEn <= en;
    drvBoot <= b;
    drvAsync <= a;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic scen_capture(input int i);
    logic [1:0] b;
    logic [3:0] a;
    logic [31:0] st;
    logic [31:0] pad;
    b = i[1:0];
    a = cfgTab[i];
    st = {23'h0, 1'b1, 2'h0, a, b};
    pad = {27'h0, a[0], a[0], a[2:1], a[3]};
    // the last pass leaves the straps to the pulls
    por(i != 4, (i == 4) ? 2'h3 : b, (i == 4) ? 4'h2 : a);
    chk({30'h0, bootMethod}, {30'h0, b});
    chk({28'h0, asyncPortConfig}, {28'h0, a});
    chk({31'h0, strapCaptured}, 32'h00000001);
    chk({27'h0, padFunctionSelectTwo}, pad);
    apb(1'b0, `BSS_ADDR_STATUS, 32'h00000000);
    chk(rd, st);
    apb(1'b0, `BSS_ADDR_PADSEL2, 32'h00000000);
    chk(rd, pad);
    drvEn <= 1'b1;
    drvBoot <= ~b;
    drvAsync <= ~a;
    apb(1'b0, `BSS_ADDR_STATUS, 32'h00000000);
    chk(rd, st);
    chk({26'h0, bootMethod, asyncPortConfig}, {26'h0, b, a});
  endtask

  task automatic scen_pins(input logic [1:0] b);
    logic [31:0] sel;
    sel = (b == `BSS_BOOT_CARD) ? 32'h00000002 : 32'h00000001;
    chk({30'h0, bootLedOe, bootLedOut}, 32'h00000003);
    chk({30'h0, serial1SelectZeroOe, serial1SelectZeroOut}, sel);
    apb(1'b1, `BSS_ADDR_BOOTCTRL, 32'h00000001);
    repeat (2) @(posedge mclk);
    #1;
    chk({30'h0, bootLedOe, bootLedOut}, 32'h00000002);
    chk({31'h0, bootMethodStrap[1]}, 32'h00000000);
    chk({30'h0, serial1SelectZeroOe, serial1SelectZeroOut}, sel);
    apb(1'b1, `BSS_ADDR_BOOTCTRL, 32'h00000003);
    repeat (2) @(posedge mclk);
    #1;
    chk({30'h0, bootLedOe, bootLedOut}, 32'h00000001);
    chk({30'h0, serial1SelectZeroOe, serial1SelectZeroOut}, 32'h00000001);
  endtask

  task automatic scen_regs(input logic [31:0] st);
    apb(1'b1, `BSS_ADDR_PADSEL2, 32'h00000015);
    apb(1'b0, `BSS_ADDR_PADSEL2, 32'h00000000);
    chk(rd, 32'h00000015);
    chk({27'h0, padFunctionSelectTwo}, 32'h00000015);
    apb(1'b1, `BSS_ADDR_STATUS, 32'hFFFFFFFF);
    chk({31'h0, er}, 32'h00000000);
    apb(1'b0, `BSS_ADDR_STATUS, 32'h00000000);
    chk(rd, st);
    apb(1'b0, 12'h00C, 32'h00000000);
    chk({31'h0, er}, 32'h00000001);
    chk(rd, 32'h00000000);
  endtask

  task automatic results();
    $display("compared=%0d mismatches=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ceiling is over fifteen times the length of the full sequence
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      results();
    end
  end

  initial begin
    for (int i = 0; i < 5; i++) begin
      scen_capture(i);
      scen_pins(i[1:0]);
    end
    scen_regs(32'h00000134);
    results();
  end
endmodule

`default_nettype wire

// >>> tb/bss_strap_board.sv
`timescale 1ns/1ps
`default_nettype none

module bss_strap_board (
  // board drivers
  input  wire logic       drvEn,
  input  wire logic [1:0] drvBoot,
  input  wire logic [3:0] drvAsync,
  // device side of the shared light pin
  input  wire logic       ledOut,
  input  wire logic       ledOe,
  // strap pin levels
  output var  logic [1:0] bootPins,
  output var  logic [3:0] asyncPins
);
  // undriven straps fall to their pulls, so the bench can see pull levels captured
  always_comb begin
    bootPins  = drvEn ? drvBoot : 2'h0;
    asyncPins = drvEn ? drvAsync : 4'hD;
    // a strap resistor loses to the device driving the light
    if (ledOe) begin
      bootPins[1] = ledOut;
    end
  end
endmodule

`default_nettype wire

// >>> verilog/bss_boot_strap_sampler.sv
// Operation
// - the two boot method straps are sampled at power-on reset and pick the boot method.
// - in ROM boot modes the upper boot strap pin then drives an active-low boot status light.
// - the four async port straps are sampled at power-on reset to set the port's reset setup.
// - async strap bit 3 sets the default of the upper data byte field, 16 or 8 bit width.
// - async strap bits 2:1 set the default function of the bank address zero pin.
// - async strap bit 0 sets the defaults of both address width fields.
// - during a card boot serial port one select zero is driven low as card power control.
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "bss_regs.svh"

module bss_boot_strap_sampler (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`BSS_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output var  logic                   pready,
  output var  logic [31:0]            prdata,
  output var  logic                   pslverr,
  // strap pins
  input  wire logic [1:0]             bootMethodStrap,
  input  wire logic [3:0]             asyncPortConfigStrap,
  // captured values
  output var  logic [1:0]             bootMethod,
  output var  logic [3:0]             asyncPortConfig,
  output var  logic                   strapCaptured,
  output var  bss_pkg::bss_pinmux_s   padFunctionSelectTwo,
  // boot status light on the upper boot strap pin
  output var  logic                   bootLedOut,
  output var  logic                   bootLedOe,
  // serial one select zero, card power
  output var  logic                   serial1SelectZeroOut,
  output var  logic                   serial1SelectZeroOe
);

  bss_pkg::bss_strap_s strapPins;
  bss_pkg::bss_strap_s strapHeld;
  logic [1:0]          bootCtrl_reg;
  logic                apbAccess;
  logic                apbCommit;
  logic                romMode;
  logic                cardBoot;
  logic                bootActive;
  logic [31:0]         readData;
  logic                addrHit;
  logic [3:0]          romMask;

  // one driver for the whole struct; field order matches the struct
  assign strapPins = {bootMethodStrap, asyncPortConfigStrap};

  bss_strap_latch u_latch (
    .mclk      (mclk),
    .rst       (rst),
    .strapIn   (strapPins),
    .strapHeld (strapHeld),
    .captured  (strapCaptured)
  );

  assign bootMethod      = strapHeld.bootMethod;
  assign asyncPortConfig = strapHeld.asyncCfg;

  // one bit per boot code, so a later non-ROM code only clears its own bit
  assign romMask    = `BSS_ROM_MODE_MASK;
  assign romMode    = romMask[strapHeld.bootMethod];
  assign cardBoot   = strapHeld.bootMethod == `BSS_BOOT_CARD;
  assign bootActive = strapCaptured && !bootCtrl_reg[`BSS_BC_BOOT_DONE];

  // one wait state: pready rises the cycle after the access phase opens
  assign apbAccess = psel && penable && !pready;
  assign apbCommit = psel && penable && pready;

  always_comb begin
    readData = `BSS_DATA_ZERO;
    addrHit  = 1'b1;
    unique case (paddr)
      `BSS_ADDR_STATUS: begin
        readData[`BSS_ST_BOOT_MSB:`BSS_ST_BOOT_LSB]   = strapHeld.bootMethod;
        readData[`BSS_ST_ASYNC_MSB:`BSS_ST_ASYNC_LSB] = strapHeld.asyncCfg;
        readData[`BSS_ST_CAPTURED]                    = strapCaptured;
      end
      `BSS_ADDR_PADSEL2: begin
        readData[`BSS_PS_UPPER_ADDR:`BSS_PS_UPPER_DATA] = padFunctionSelectTwo;
      end
      `BSS_ADDR_BOOTCTRL: begin
        readData[`BSS_BC_BOOT_DONE:`BSS_BC_LED_ON] = bootCtrl_reg;
      end
      default: begin
        addrHit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= `BSS_DATA_ZERO;
      pslverr <= 1'b0;
    end else begin
      pready  <= apbAccess;
      prdata  <= (apbAccess && !pwrite) ? readData : `BSS_DATA_ZERO;
      pslverr <= apbAccess && !addrHit;
    end
  end

  // pad select defaults come from the straps; software may override later
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      padFunctionSelectTwo <= `BSS_PS_RESET;
    end else if (!strapCaptured) begin
      padFunctionSelectTwo.upperDataByte  <= asyncPortConfigStrap[`BSS_AC_WIDTH];
      padFunctionSelectTwo.bankAddrZero   <=
        asyncPortConfigStrap[`BSS_AC_BANK0_MSB:`BSS_AC_BANK0_LSB];
      padFunctionSelectTwo.lowAddrBankOne <= asyncPortConfigStrap[`BSS_AC_ADDRW];
      padFunctionSelectTwo.upperAddr      <= asyncPortConfigStrap[`BSS_AC_ADDRW];
    end else if (apbCommit && pwrite && paddr == `BSS_ADDR_PADSEL2) begin
      padFunctionSelectTwo <= pwdata[`BSS_PS_UPPER_ADDR:`BSS_PS_UPPER_DATA];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bootCtrl_reg <= `BSS_BC_RESET;
    end else if (apbCommit && pwrite && paddr == `BSS_ADDR_BOOTCTRL) begin
      // boot done is sticky: once the pins are handed back they stay so
      bootCtrl_reg[`BSS_BC_LED_ON]    <= pwdata[`BSS_BC_LED_ON];
      bootCtrl_reg[`BSS_BC_BOOT_DONE] <= pwdata[`BSS_BC_BOOT_DONE]
                                         || bootCtrl_reg[`BSS_BC_BOOT_DONE];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bootLedOut <= 1'b1;
      bootLedOe  <= 1'b0;
    end else begin
      bootLedOe  <= bootActive && romMode;
      bootLedOut <= !(bootActive && romMode && bootCtrl_reg[`BSS_BC_LED_ON]);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      serial1SelectZeroOut <= 1'b1;
      serial1SelectZeroOe  <= 1'b0;
    end else begin
      serial1SelectZeroOe  <= bootActive && cardBoot;
      serial1SelectZeroOut <= !(bootActive && cardBoot);
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence seqCapture;
    !strapCaptured ##1 strapCaptured;
  endsequence

  sequence seqCardBoot;
    bootActive && cardBoot;
  endsequence

  AST_BOOT_CAPTURE: assert property (
    seqCapture |-> bootMethod == $past(bootMethodStrap))
    else $error("boot method not taken from straps");

  AST_LED_DRIVE: assert property (
    bootActive && romMode && bootCtrl_reg[`BSS_BC_LED_ON] |=> bootLedOe && !bootLedOut)
    else $error("boot status light not driven low");

  AST_ASYNC_CAPTURE: assert property (
    seqCapture |-> asyncPortConfig == $past(asyncPortConfigStrap))
    else $error("async config not taken from straps");

  AST_WIDTH_DEFAULT: assert property (
    seqCapture |-> padFunctionSelectTwo.upperDataByte == asyncPortConfig[`BSS_AC_WIDTH])
    else $error("data width default wrong");

  AST_BANK_DEFAULT: assert property (
    seqCapture |-> padFunctionSelectTwo.bankAddrZero
                   == asyncPortConfig[`BSS_AC_BANK0_MSB:`BSS_AC_BANK0_LSB])
    else $error("bank pin default wrong");

  AST_ADDRW_DEFAULT: assert property (
    seqCapture |-> padFunctionSelectTwo.lowAddrBankOne == asyncPortConfig[`BSS_AC_ADDRW]
                   && padFunctionSelectTwo.upperAddr == asyncPortConfig[`BSS_AC_ADDRW])
    else $error("address width defaults wrong");

  AST_CARD_POWER: assert property (
    seqCardBoot ##1 seqCardBoot |-> serial1SelectZeroOe && !serial1SelectZeroOut)
    else $error("card power select not low");

  AST_STRAP_HOLD: assert property (
    strapCaptured |=> strapCaptured && $stable(bootMethod) && $stable(asyncPortConfig))
    else $error("captured straps changed");

  AST_APB_WAIT: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one wait state");

  AST_APB_ERROR: assert property (
    apbAccess && !addrHit |=> pready && pslverr && prdata == `BSS_DATA_ZERO)
    else $error("unmapped access not refused");

  AST_LED_OFF: assert property (
    bootActive && romMode && !bootCtrl_reg[`BSS_BC_LED_ON] |=> bootLedOe && bootLedOut)
    else $error("boot status light lit while off");

  AST_PIN_RELEASE: assert property (
    strapCaptured && bootCtrl_reg[`BSS_BC_BOOT_DONE]
    |=> !bootLedOe && !serial1SelectZeroOe && serial1SelectZeroOut)
    else $error("boot pins not released after boot done");

endmodule

`default_nettype wire

// >>> verilog/bss_pkg.sv
`default_nettype none
`include "bss_regs.svh"

package bss_pkg;

  typedef enum logic [1:0] {
    BOOT_NAND = `BSS_BOOT_NAND,
    BOOT_CARD = `BSS_BOOT_CARD,
    BOOT_USB  = `BSS_BOOT_USB,
    BOOT_UART = `BSS_BOOT_UART
  } bss_boot_e;

  typedef enum logic [1:0] {
    PH_CAPTURE = 2'b01,
    PH_HELD    = 2'b10
  } bss_phase_e;

  typedef struct packed {
    logic [1:0] bootMethod;
    logic [3:0] asyncCfg;
  } bss_strap_s;

  typedef struct packed {
    logic       upperAddr;
    logic       lowAddrBankOne;
    logic [1:0] bankAddrZero;
    logic       upperDataByte;
  } bss_pinmux_s;

endpackage

`default_nettype wire

// >>> verilog/bss_regs.svh
`ifndef BSS_REGS_SVH
`define BSS_REGS_SVH

// register byte addresses
`define BSS_ADDR_W           12
`define BSS_ADDR_STATUS      12'h000
`define BSS_ADDR_PADSEL2     12'h004
`define BSS_ADDR_BOOTCTRL    12'h008

// status register fields
`define BSS_ST_BOOT_LSB      0
`define BSS_ST_BOOT_MSB      1
`define BSS_ST_ASYNC_LSB     2
`define BSS_ST_ASYNC_MSB     5
`define BSS_ST_CAPTURED      8

// pad function select two fields
`define BSS_PS_UPPER_DATA    0
`define BSS_PS_BANK0_LSB     1
`define BSS_PS_BANK0_MSB     2
`define BSS_PS_LOW_ADDR      3
`define BSS_PS_UPPER_ADDR    4
`define BSS_PS_RESET         5'h00

// boot control fields
`define BSS_BC_LED_ON        0
`define BSS_BC_BOOT_DONE     1
`define BSS_BC_RESET         2'h0

// strap field positions
`define BSS_AC_WIDTH         3
`define BSS_AC_BANK0_LSB     1
`define BSS_AC_BANK0_MSB     2
`define BSS_AC_ADDRW         0

// boot method codes; every code boots from the on-chip ROM
`define BSS_BOOT_NAND        2'h0
`define BSS_BOOT_CARD        2'h1
`define BSS_BOOT_USB         2'h2
`define BSS_BOOT_UART        2'h3
`define BSS_ROM_MODE_MASK    4'hF

`define BSS_DATA_ZERO        32'h00000000

`endif

// >>> verilog/bss_strap_latch.sv
`timescale 1ns/1ps
`default_nettype none

module bss_strap_latch (
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            rst,
  // strap pins
  input  wire bss_pkg::bss_strap_s strapIn,
  // held values
  output var  bss_pkg::bss_strap_s strapHeld,
  output var  logic            captured
);

  bss_pkg::bss_phase_e phase_reg;

  // straps are taken on the first edge after release, since an async
  // reset may only load constants
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_reg <= bss_pkg::PH_CAPTURE;
    end else begin
      unique case (phase_reg)
        bss_pkg::PH_CAPTURE: begin
          phase_reg <= bss_pkg::PH_HELD;
        end
        bss_pkg::PH_HELD: begin
          phase_reg <= bss_pkg::PH_HELD;
        end
        default: begin
          phase_reg <= bss_pkg::PH_CAPTURE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      strapHeld <= '0;
      captured  <= 1'b0;
    end else if (phase_reg == bss_pkg::PH_CAPTURE) begin
      strapHeld <= strapIn;
      captured  <= 1'b1;
    end
  end

endmodule

`default_nettype wire
